/* rtl/afp_arc_top.sv */
// Summary of operation
// - four stages: two phase, two earth
// - earth stages use residual current only
// - selector has eight light source codes
// - selection none starts or trips only when forced
// - trip needs light and current together unless forced
// - start whenever selected light is seen
// - trip on selected light plus overcurrent
// - light counter counts every source's light
// - per stage start and trip counters
// - counters clear on request, to one if an event comes in that cycle
// - shared force flag self-clears after 5 min
// - forced status writes need force flag
// - settings writable only after password
// - delayed light after 0.01 to 0.15 s
// - delayed light has own selector, delay
// - remote light input offered to matrix
// - link output driven by matrix OR
// - pickups held per-unit of own input
// - keep eight latest fault records
// - type and load only for stage one
// - elapsed delay stored as percent
//
// Implementation choices: the placing of the registers and the strobed register port.
module afp_arc_top #(
  parameter longint FORCE_CYCLES = afp_pkg::FORCE_CYCLES, // Force timeout in clocks
  parameter int     STEP_CYCLES  = afp_pkg::STEP_CYCLES   // Clocks per 10 ms step
) (
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_RESET,
  input  wire afp_pkg::afp_light_t I_LIGHT,          // Sensors and remote input
  input  wire logic [15:0]       I_PHASE_PEAK_A,     // Phase current peak, group one, pu 8.8
  input  wire logic [15:0]       I_PHASE_PEAK_B,     // Phase current peak, group two
  input  wire logic [15:0]       I_RESID_ONE,        // Residual input one
  input  wire logic [15:0]       I_RESID_TWO,        // Residual input two
  input  wire logic [15:0]       I_LOAD_CURRENT,     // Pre-fault load, group one
  input  wire logic [7:0]        I_FAULT_TYPE,       // Fault type, group one
  input  wire logic [31:0]       I_TIME_MS,          // Time of day in ms
  input  wire logic [31:0]       I_DATE,             // Date stamp
  input  wire logic [15:0]       I_MATRIX_SIGNALS,   // Other matrix sources
  input  wire logic [7:0]        I_ADDR,
  input  wire logic [31:0]       I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  output logic [31:0]            O_RDATA,
  output logic [3:0]             O_START,
  output logic [3:0]             O_TRIP,
  output logic                   O_DELAYED_LIGHT,
  output logic                   O_MATRIX_REMOTE,
  output logic                   O_LINK_OUT
);
  localparam int NS = afp_pkg::NUM_STAGES;

  logic              force_flag;              // Shared test forcing flag
  longint            force_cnt;               // Force age in clocks
  logic              unlocked;                // Password accepted
  logic [15:0]       pickup    [NS];          // Per-unit pickups
  afp_pkg::afp_sel_t sel       [NS];          // Stage light selections
  afp_pkg::afp_sel_t dly_sel;                 // Delayed light selection
  logic [7:0]        dly_steps;               // Delay in 10 ms steps
  logic [3:0]        force_start;             // Forced start bits
  logic [3:0]        force_trip;              // Forced trip bits
  logic [31:0]       start_cnt [NS];          // Start counters
  logic [31:0]       trip_cnt  [NS];          // Trip counters
  logic [31:0]       light_cnt;               // Common light counter
  logic [15:0]       link_mask;               // Matrix mask for link output
  logic [2:0]        rec_idx;                 // Fault read index
  logic [15:0]       current   [NS];          // Supervised current per stage
  logic [3:0]        light_sel;               // Selected light per stage
  logic [3:0]        raw_start;
  logic [3:0]        raw_trip;
  logic [3:0]        prev_start;              // For edge counting
  logic [3:0]        prev_trip;
  logic              any_light;
  logic              prev_any_light;
  logic              dly_light;               // Delayed light source
  logic [7:0]        dly_step_cnt;
  int                dly_clk_cnt;
  logic              wr_ok;                   // Setting write allowed
  logic              clr_cnt;                 // Counter clear pulse
  logic              rec_wr;
  afp_pkg::afp_rec_t new_rec;
  afp_pkg::afp_rec_t rd_rec;
  logic [3:0]        rec_count;
  logic [1:0]        trip_stage;
  logic [31:0]       next_rdata;
  logic [7:0]        stg_off;
  logic [1:0]        stg_idx;

  assign current[0] = I_PHASE_PEAK_A;
  assign current[1] = I_PHASE_PEAK_B;
  assign current[2] = I_RESID_ONE;
  assign current[3] = I_RESID_TWO;

  // Stage logic, one instance per stage
  genvar g;
  generate
    for (g = 0; g < NS; g++)
    begin : g_stage
      afp_light_sel u_sel (
        .i_light_s1     (I_LIGHT.s1),
        .i_light_s2     (I_LIGHT.s2),
        .i_light_remote (I_LIGHT.remote),
        .i_sel          (sel[g]),
        .o_light        (light_sel[g])
      );
      assign raw_start[g] = light_sel[g];
      assign raw_trip[g]  = light_sel[g] & (current[g] >= pickup[g]);
    end
  endgenerate

  // Forced bits only take effect while the flag stands
  assign O_START = raw_start | (force_start & {4{force_flag}});
  assign O_TRIP  = raw_trip  | (force_trip  & {4{force_flag}});

  assign O_MATRIX_REMOTE = I_LIGHT.remote;

  assign wr_ok   = I_WR & unlocked;
  assign clr_cnt = I_WR && I_ADDR == afp_pkg::REG_CTRL && I_WDATA[afp_pkg::CTRL_CLR_CNT];
  assign stg_off = I_ADDR - afp_pkg::REG_STAGE_BASE;
  assign stg_idx = stg_off[5:4];

  // Password unlock: upper half of a control write carries the key
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
    begin
      unlocked <= 1'b0;
    end
    else if (I_WR && I_ADDR == afp_pkg::REG_CTRL)
    begin
      unlocked <= I_WDATA[afp_pkg::CTRL_UNLOCK] && I_WDATA[31:16] == afp_pkg::PASSWORD;
    end
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
    begin
      force_flag <= 1'b0;
      force_cnt  <= 0;
    end
    else if (wr_ok && I_ADDR == afp_pkg::REG_CTRL)
    begin
      force_flag <= I_WDATA[afp_pkg::CTRL_FORCE];
      force_cnt  <= 0;
    end
    else if (force_flag)
    begin
      if (force_cnt >= FORCE_CYCLES - 1)
      begin
        force_flag <= 1'b0;
        force_cnt  <= 0;
      end
      else
      begin
        force_cnt <= force_cnt + 1;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
    begin
      force_start <= 4'h0;
      force_trip  <= 4'h0;
    end
    else if (I_WR && I_ADDR == afp_pkg::REG_FORCE_ST && force_flag)
    begin
      force_start <= I_WDATA[3:0];
      force_trip  <= I_WDATA[7:4];
    end
    else if (!force_flag)
    begin
      // Forced state drops with the flag, so timeout cannot leave a forced trip
      force_start <= 4'h0;
      force_trip  <= 4'h0;
    end
  end

  // Settings: pickups, selections, delay and link mask
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
    begin
      for (int i = 0; i < NS; i++)
      begin
        pickup[i] <= afp_pkg::PICKUP_RESET;
        sel[i]    <= afp_pkg::SEL_NONE;
      end
      dly_sel   <= afp_pkg::SEL_NONE;
      dly_steps <= afp_pkg::DELAY_RESET;
      link_mask <= 16'h0000;
    end
    else if (wr_ok)
    begin
      if (I_ADDR == afp_pkg::REG_LIGHT_CFG)
      begin
        dly_sel <= afp_pkg::afp_sel_t'(I_WDATA[2:0]);
        if (I_WDATA[15:8] < 8'(afp_pkg::DELAY_MIN))
        begin
          dly_steps <= 8'(afp_pkg::DELAY_MIN);
        end
        else if (I_WDATA[15:8] > 8'(afp_pkg::DELAY_MAX))
        begin
          dly_steps <= 8'(afp_pkg::DELAY_MAX);
        end
        else
        begin
          dly_steps <= I_WDATA[15:8];
        end
      end
      else if (I_ADDR == afp_pkg::REG_LINK_SEL)
      begin
        link_mask <= I_WDATA[15:0];
      end
      else if (I_ADDR >= afp_pkg::REG_STAGE_BASE && stg_off < 8'h40)
      begin
        if (stg_off[3:0] == afp_pkg::STG_PICKUP[3:0])
        begin
          pickup[stg_idx] <= I_WDATA[15:0];
        end
        else if (stg_off[3:0] == afp_pkg::STG_SELECT[3:0])
        begin
          sel[stg_idx] <= afp_pkg::afp_sel_t'(I_WDATA[2:0]);
        end
      end
    end
  end

  // Edge history for counting events once
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
    begin
      prev_start     <= 4'h0;
      prev_trip      <= 4'h0;
      prev_any_light <= 1'b0;
    end
    else
    begin
      prev_start     <= O_START;
      prev_trip      <= O_TRIP;
      prev_any_light <= any_light;
    end
  end

  assign any_light = I_LIGHT.s1 | I_LIGHT.s2 | I_LIGHT.remote;

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
    begin
      light_cnt <= 32'h0;
    end
    else if (any_light && !prev_any_light)
    begin
      light_cnt <= clr_cnt ? 32'h1 : light_cnt + 32'h1;
    end
    else if (clr_cnt)
    begin
      light_cnt <= 32'h0;
    end
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
    begin
      for (int i = 0; i < NS; i++)
      begin
        start_cnt[i] <= 32'h0;
        trip_cnt[i]  <= 32'h0;
      end
    end
    else
    begin
      for (int i = 0; i < NS; i++)
      begin
        if (O_START[i] && !prev_start[i])
        begin
          start_cnt[i] <= clr_cnt ? 32'h1 : start_cnt[i] + 32'h1;
        end
        else if (clr_cnt)
        begin
          start_cnt[i] <= 32'h0;
        end
        if (O_TRIP[i] && !prev_trip[i])
        begin
          trip_cnt[i] <= clr_cnt ? 32'h1 : trip_cnt[i] + 32'h1;
        end
        else if (clr_cnt)
        begin
          trip_cnt[i] <= 32'h0;
        end
      end
    end
  end

  afp_light_sel u_dly_sel (
    .i_light_s1     (I_LIGHT.s1),
    .i_light_s2     (I_LIGHT.s2),
    .i_light_remote (I_LIGHT.remote),
    .i_sel          (dly_sel),
    .o_light        (dly_light)
  );

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET || !dly_light)
    begin
      dly_clk_cnt     <= 0;
      dly_step_cnt    <= 8'h0;
      O_DELAYED_LIGHT <= 1'b0;
    end
    else if (dly_step_cnt >= dly_steps)
    begin
      O_DELAYED_LIGHT <= 1'b1;
    end
    else if (dly_clk_cnt >= STEP_CYCLES - 1)
    begin
      dly_clk_cnt  <= 0;
      dly_step_cnt <= dly_step_cnt + 8'h1;
    end
    else
    begin
      dly_clk_cnt <= dly_clk_cnt + 1;
    end
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
    begin
      O_LINK_OUT <= 1'b0;
    end
    else
    begin
      O_LINK_OUT <= |(link_mask & {I_MATRIX_SIGNALS[15:3], O_DELAYED_LIGHT, |O_TRIP, I_LIGHT.remote});
    end
  end

  // Lowest numbered stage that trips now is logged
  always_comb
  begin
    trip_stage = 2'h0;
    for (int i = NS - 1; i >= 0; i--)
    begin
      if (O_TRIP[i] && !prev_trip[i])
      begin
        trip_stage = 2'(i);
      end
    end
  end
  assign rec_wr = |(O_TRIP & ~prev_trip);

  // Arc trips are instantaneous, so a record always shows full delay
  always_comb
  begin
    new_rec         = '0;
    new_rec.date    = I_DATE;
    new_rec.time_ms = I_TIME_MS;
    new_rec.value   = current[trip_stage];
    new_rec.stage   = trip_stage;
    new_rec.elapsed_delay_pct    = 8'(afp_pkg::PCT_FULL);
    if (trip_stage == 2'h0)
    begin
      new_rec.ftype = I_FAULT_TYPE;
      new_rec.load  = I_LOAD_CURRENT;
    end
  end

  afp_fault_log u_log (
    .i_clk    (I_CORE_CLK),
    .i_reset  (I_RESET),
    .i_wr     (rec_wr),
    .i_rec    (new_rec),
    .i_rd_idx (rec_idx),
    .o_rec    (rd_rec),
    .o_count  (rec_count)
  );

  // Record read index is not a setting, so no password
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
    begin
      rec_idx <= 3'h0;
    end
    else if (I_WR && I_ADDR == afp_pkg::REG_FLT_PTR)
    begin
      rec_idx <= I_WDATA[2:0];
    end
  end

  // Read mux; unmapped reads answer zero
  always_comb
  begin
    next_rdata = 32'h0;
    unique case (I_ADDR)
      afp_pkg::REG_CTRL:      next_rdata = {29'h0, clr_cnt, unlocked, force_flag};
      afp_pkg::REG_LIGHT_CFG: next_rdata = {16'h0, dly_steps, 5'h0, dly_sel};
      afp_pkg::REG_STATUS:    next_rdata = {20'h0, I_LIGHT, O_DELAYED_LIGHT, O_TRIP, O_START};
      afp_pkg::REG_FORCE_ST:  next_rdata = {24'h0, force_trip, force_start};
      afp_pkg::REG_LIGHT_CNT: next_rdata = light_cnt;
      afp_pkg::REG_LINK_SEL:  next_rdata = {16'h0, link_mask};
      afp_pkg::REG_FLT_PTR:   next_rdata = {20'h0, rec_count, 5'h0, rec_idx};
      afp_pkg::REG_FLT_DATA0: next_rdata = {14'h0, rd_rec.stage, rd_rec.ftype, rd_rec.elapsed_delay_pct};
      afp_pkg::REG_FLT_DATA1: next_rdata = {rd_rec.value, rd_rec.load};
      afp_pkg::REG_FLT_TIME:  next_rdata = rd_rec.time_ms;
      afp_pkg::REG_FLT_DATE:  next_rdata = rd_rec.date;
      default:
      begin
        if (I_ADDR >= afp_pkg::REG_STAGE_BASE && stg_off < 8'h40)
        begin
          case (stg_off[3:0])
            afp_pkg::STG_PICKUP[3:0]:    next_rdata = {16'h0, pickup[stg_idx]};
            afp_pkg::STG_SELECT[3:0]:    next_rdata = {29'h0, sel[stg_idx]};
            afp_pkg::STG_START_CNT[3:0]: next_rdata = start_cnt[stg_idx];
            afp_pkg::STG_TRIP_CNT[3:0]:  next_rdata = trip_cnt[stg_idx];
            default:                     next_rdata = 32'h0;
          endcase
        end
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET || !I_RD)
    begin
      O_RDATA <= 32'h0;
    end
    else
    begin
      O_RDATA <= next_rdata;
    end
  end

  AST_NONE_QUIET: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (sel[0] == afp_pkg::SEL_NONE && !force_flag) |-> !O_START[0] && !O_TRIP[0])
    else $error("stage with no light source active");
  AST_TRIP_NEEDS_BOTH: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (O_TRIP[0] && !force_flag) |-> light_sel[0] && I_PHASE_PEAK_A >= pickup[0])
    else $error("trip without light and current");
  AST_START_LIGHT: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (sel[2] == afp_pkg::SEL_BI && !force_flag) |-> O_START[2] == I_LIGHT.remote)
    else $error("selected light without start");
  AST_FORCE_GATE: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_WR && I_ADDR == afp_pkg::REG_FORCE_ST && !force_flag) |=> force_start == 4'h0)
    else $error("forced write taken without flag");
  AST_LOCKED: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_WR && !unlocked && I_ADDR == afp_pkg::REG_LINK_SEL) |=> $stable(link_mask))
    else $error("setting changed while locked");
  AST_CNT_GROWS: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    !$past(clr_cnt) |-> light_cnt >= $past(light_cnt))
    else $error("light counter decreased without clear");
  AST_TRIP_COUNT: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (O_TRIP[0] && !prev_trip[0] && !clr_cnt) |=> trip_cnt[0] == $past(trip_cnt[0]) + 32'h1)
    else $error("trip not counted");
  AST_DLY_OFF: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    !dly_light |=> !O_DELAYED_LIGHT)
    else $error("delayed light without source");
  AST_DLY_NOT_EARLY: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    $rose(dly_light) |-> !O_DELAYED_LIGHT [*2])
    else $error("delayed light too early");
  AST_REMOTE_MATRIX: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    O_MATRIX_REMOTE == I_LIGHT.remote)
    else $error("remote light not offered");
  AST_ELAPSED_DELAY_PCT_FULL: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    rec_wr |-> new_rec.elapsed_delay_pct == 8'h64)
    else $error("elapsed delay not full");
  COV_TRIP: cover property (@(posedge I_CORE_CLK) disable iff (I_RESET) $rose(O_TRIP[0]));
  COV_DLY: cover property (@(posedge I_CORE_CLK) disable iff (I_RESET) $rose(O_DELAYED_LIGHT));
  COV_FORCE: cover property (@(posedge I_CORE_CLK) disable iff (I_RESET) $fell(force_flag));
  COV_FULL_LOG: cover property (@(posedge I_CORE_CLK) disable iff (I_RESET) rec_wr && rec_count == 4'h8);
endmodule : afp_arc_top

/* rtl/afp_fault_log.sv */
// Ring of the eight newest fault records
module afp_fault_log (
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  input  wire logic              i_wr,
  input  wire afp_pkg::afp_rec_t i_rec,
  input  wire logic [2:0]        i_rd_idx, // 0 = newest
  output afp_pkg::afp_rec_t      o_rec,
  output logic [3:0]             o_count
);
  afp_pkg::afp_rec_t mem [afp_pkg::NUM_RECORDS]; // Record storage
  logic [2:0]        wr_ptr;                      // Next slot to fill
  logic [2:0]        rd_slot;                     // Slot behind the read index

  always_ff @(posedge i_clk)
  begin
    if (i_wr)
    begin
      mem[wr_ptr] <= i_rec;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      wr_ptr  <= 3'h0;
      o_count <= 4'h0;
    end
    else if (i_wr)
    begin
      wr_ptr <= wr_ptr + 3'h1;
      if (o_count != 4'h8)
      begin
        o_count <= o_count + 4'h1;
      end
    end
  end

  // Newest is one slot behind the write pointer
  assign rd_slot = wr_ptr - 3'h1 - i_rd_idx;

  // Registered read keeps the data output on a flip-flop
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_rec <= '0;
    end
    else
    begin
      o_rec <= mem[rd_slot];
    end
  end
endmodule : afp_fault_log

/* rtl/afp_light_sel.sv */
// Light source selector: one bit per source, so codes combine by OR
module afp_light_sel (
  input  wire logic              i_light_s1,
  input  wire logic              i_light_s2,
  input  wire logic              i_light_remote,
  input  wire afp_pkg::afp_sel_t i_sel,
  output logic                   o_light
);
  assign o_light = (i_sel[0] & i_light_s1) | (i_sel[1] & i_light_s2) | (i_sel[2] & i_light_remote);
endmodule : afp_light_sel

/* rtl/afp_pkg.sv */
package afp_pkg;
  // Register offsets (byte address, word index = address / 4)
  localparam logic [7:0] REG_CTRL        = 8'h00; // Force, password unlock, counter clear
  localparam logic [7:0] REG_LIGHT_CFG   = 8'h04; // Delayed light select and delay
  localparam logic [7:0] REG_STATUS      = 8'h08; // Start/trip per stage, delayed light, pins
  localparam logic [7:0] REG_FORCE_ST    = 8'h0c; // Forced start/trip bits
  localparam logic [7:0] REG_LIGHT_CNT   = 8'h10; // Common light counter
  localparam logic [7:0] REG_LINK_SEL    = 8'h14; // Output matrix mask for the link output
  localparam logic [7:0] REG_FLT_PTR     = 8'h18; // Fault record count and read index
  localparam logic [7:0] REG_FLT_DATA0   = 8'h1c; // Record word: stage, type, elapsed delay
  localparam logic [7:0] REG_FLT_DATA1   = 8'h20; // Record word: fault value, load
  localparam logic [7:0] REG_FLT_TIME    = 8'h24; // Record word: time of day in ms
  localparam logic [7:0] REG_FLT_DATE    = 8'h28; // Record word: date
  localparam logic [7:0] REG_STAGE_BASE  = 8'h40; // Per stage block of 16 bytes
  localparam logic [7:0] STG_PICKUP      = 8'h00; // Pickup, per-unit
  localparam logic [7:0] STG_SELECT      = 8'h04; // Light source selection
  localparam logic [7:0] STG_START_CNT   = 8'h08; // Start counter
  localparam logic [7:0] STG_TRIP_CNT    = 8'h0c; // Trip counter
  // Control bit positions
  localparam int CTRL_FORCE   = 0;
  localparam int CTRL_UNLOCK  = 1;
  localparam int CTRL_CLR_CNT = 2;
  // Password value that opens setting writes (arbitrary)
  localparam logic [15:0] PASSWORD = 16'h5a3c;
  // Reset values
  localparam logic [15:0] PICKUP_RESET = 16'h0100; // 1.00 pu in 8.8 format
  localparam logic [7:0]  DELAY_RESET  = 8'h01;    // 10 ms steps
  // Timing: 10 MHz core, 10 ms delay step, 5 minute force timeout
  localparam int CLK_HZ        = 10_000_000;
  localparam int DELAY_STEP_MS = 10;
  localparam int DELAY_MIN     = 1;   // 0.01 s
  localparam int DELAY_MAX     = 15;  // 0.15 s
  localparam int STEP_CYCLES   = CLK_HZ / 1000 * DELAY_STEP_MS;
  localparam int FORCE_MIN     = 5;
  localparam longint FORCE_CYCLES = longint'(CLK_HZ) * 60 * FORCE_MIN;
  localparam int NUM_STAGES    = 4;
  localparam int NUM_RECORDS   = 8;
  localparam int PCT_FULL      = 100;

  // Light source selection codes
  typedef enum logic [2:0] {
    SEL_NONE     = 3'b000,
    SEL_S1       = 3'b001,
    SEL_S2       = 3'b010,
    SEL_S1_S2    = 3'b011,
    SEL_BI       = 3'b100,
    SEL_S1_BI    = 3'b101,
    SEL_S2_BI    = 3'b110,
    SEL_S1_S2_BI = 3'b111
  } afp_sel_t;

  // Light inputs bundled together
  typedef struct packed {
    logic remote; // Remote light input
    logic s2;     // Sensor two
    logic s1;     // Sensor one
  } afp_light_t;

  // One fault record
  typedef struct packed {
    logic [31:0] date;
    logic [31:0] time_ms;
    logic [15:0] value;
    logic [15:0] load;
    logic [7:0]  ftype;
    logic [7:0]  elapsed_delay_pct;
    logic [1:0]  stage;
  } afp_rec_t;
endpackage : afp_pkg

/* test/afp_light_model.sv */
// Light sensors and the far relay's dry contact
module afp_light_model (
  input  wire logic           i_clk,
  input  wire logic [2:0]     i_cmd,
  output afp_pkg::afp_light_t o_light = '0
);
  timeunit 1ns;
  timeprecision 1ns;
  // remote contact level
  // Levels change just after an edge, like a real contact
  always_ff @(posedge i_clk)
    o_light <= i_cmd;
endmodule : afp_light_model

/* test/test_arc_fault_protection_stages.sv */
module test_arc_fault_protection_stages;
  timeunit 1ns;
  timeprecision 1ns;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic [2:0]          cmd = 3'h7;   // Light on while selections are none
  logic [15:0]         pa = 16'hffff, pb = 16'hffff, r1 = 16'hffff, r2 = 16'hffff;
  logic [7:0]          addr = 8'h0;
  logic [7:0]          ft = 8'h0;    // Fault type offered to the log
  logic [31:0]         tms = 32'h0, dte = 32'h0;
  logic [31:0]         wd = 32'h0, rdata;
  logic                wr_s = 1'b0, rd_s = 1'b0, dl, mr, lo;
  logic [3:0]          st, tr;
  afp_pkg::afp_light_t light;
  int                  num_errors = 0, n_tests = 0;

  // Short force and delay counts keep the run brief
  afp_arc_top #(.FORCE_CYCLES(50), .STEP_CYCLES(10)) u_afp_arc_top (
    .I_CORE_CLK(clk), .I_RESET(rst), .I_LIGHT(light), .I_PHASE_PEAK_A(pa), .I_PHASE_PEAK_B(pb),
    .I_RESID_ONE(r1), .I_RESID_TWO(r2), .I_LOAD_CURRENT(16'h0012), .I_FAULT_TYPE(ft),
    .I_TIME_MS(tms), .I_DATE(dte), .I_MATRIX_SIGNALS(16'h0), .I_ADDR(addr), .I_WDATA(wd),
    .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .O_START(st), .O_TRIP(tr),
    .O_DELAYED_LIGHT(dl), .O_MATRIX_REMOTE(mr), .O_LINK_OUT(lo));
  afp_light_model u_afp_light_model (.i_clk(clk), .i_cmd(cmd), .o_light(light));

  initial
    forever #50 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk

  // Extra edge after the strobe so calls can follow each other
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wd   <= d;
    wr_s <= 1'b1;
    cyc(1);
    wr_s <= 1'b0;
    cyc(1);
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    addr <= a;
    rd_s <= 1'b1;
    cyc(1);
    rd_s <= 1'b0;
    #1 chk(nm, e, rdata);
    cyc(1);
  endtask : rd

  task automatic close_out();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  // Main sequence
  initial
  begin
    cyc(3);
    rst <= 1'b0;
    cyc(3);
    #1 chk("none", 0, 32'({st, tr}));
    wr(8'h44, 1);
    rd(8'h44, 0, "locked");
    wr(8'h0c, 32'hff);
    rd(8'h0c, 0, "noforce");
    cmd <= 3'h0;
    wr(8'h00, 32'h5a3c0002);
    wr(8'h44, 1);
    wr(8'h64, 4);
    rd(8'h44, 1, "sel");
    pa <= 16'h00ff;
    r1 <= 16'h0;
    cmd <= 3'h1;
    cyc(3);
    #1 chk("below", 32'h10, 32'({st, tr}));
    pa  <= 16'h0100;
    ft  <= 8'h3c;
    tms <= 32'h1000;
    dte <= 32'h0b0c;
    cyc(1);
    #1 chk("equal", 32'h11, 32'({st, tr}));
    cmd <= 3'h0;
    cyc(2);
    cmd <= 3'h4;
    cyc(3);
    #1 chk("earth", 32'h40, 32'({st, tr}));
    chk("remote", 1, 32'(mr));
    r1  <= 16'h0100;
    tms <= 32'h2000;
    cyc(1);
    #1 chk("etrip", 32'h44, 32'({st, tr}));
    cmd <= 3'h0;
    cyc(2);
    // Light held through reset counts once at release, then two more
    rd(8'h10, 3, "lcnt");
    rd(8'h48, 1, "scnt");
    rd(8'h4c, 1, "tcnt");
    rd(8'h18, 32'h200, "nrec");
    // Newest record is the earth stage: no type and no load kept
    rd(8'h1c, 32'h20064, "rec");
    rd(8'h20, 32'h01000000, "eload");
    wr(8'h18, 1);
    rd(8'h1c, 32'h3c64, "ptype");
    rd(8'h20, 32'h01000012, "pload");
    rd(8'h24, 32'h1000, "ptime");
    rd(8'h28, 32'h0b0c, "pdate");
    wr(8'h00, 32'h5a3c0006);
    rd(8'h10, 0, "clr");
    wr(8'h00, 32'h5a3c0003);
    wr(8'h0c, 32'h10);
    #1 chk("ftrip", 1, 32'(tr));
    // Flag lives 50 clocks: still up near the end, gone just after
    cyc(45);
    rd(8'h00, 3, "fset");
    rd(8'h00, 2, "fexp");
    wr(8'h04, 32'h0301);
    cmd <= 3'h1;
    // Three steps of ten clocks: quiet before, high shortly after
    cyc(30);
    #1 chk("early", 0, 32'(dl));
    cyc(3);
    #1 chk("late", 1, 32'(dl));
    wr(8'h14, 4);
    #1 chk("link", 1, 32'(lo));
    wr(8'h04, 32'h2001);
    rd(8'h04, 32'h0f01, "clamp");
    close_out();
  end

  // Run needs under 200 cycles
  initial
  begin
    cyc(3000);
    num_errors++;
    close_out();
  end
endmodule : test_arc_fault_protection_stages
